// ==== rtl/pgpc_edge_detect.sv ====
/*
 * edge detector for one pin input feeding the pin interrupt.
 * assumes the pin level is already synchronous to the clock.
 */
module pgpc_edge_detect (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_level,
    input  wire logic i_polarity,
    input  wire logic i_both_edges,
    input  wire logic i_arm,
    output logic      o_event
);
    logic level_q;
    logic rise;
    logic fall;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            level_q <= 1'b0;
        end else begin
            level_q <= i_level;
        end
    end

    assign rise = i_level & ~level_q;
    assign fall = ~i_level & level_q;

    always_comb begin
        if (!i_arm) begin
            o_event = 1'b0;
        end else if (i_both_edges) begin
            o_event = rise | fall;
        end else if (i_polarity) begin
            o_event = rise;
        end else begin
            o_event = fall;
        end
    end
endmodule : pgpc_edge_detect

// ==== rtl/pgpc_map.svh ====
/*
 * register offsets, field positions and reset values of the pin-control block.
 * assumes a plain register port with word addresses.
 */
`ifndef PGPC_MAP_SVH
`define PGPC_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define PGPC_PIN_A_CTRL_OFS   16'h403b
`define PGPC_PIN_B_CTRL_OFS   16'h403c
`define PGPC_IRQ_STAT_OFS     16'h4040
`define PGPC_IRQ_CLR_OFS      16'h4041
`define PGPC_IRQ_EN_OFS       16'h4042
`define PGPC_PIN_DATA_OFS     16'h4043

// ****************************************
// field positions
// ****************************************
`define PGPC_DIR_BIT          15
`define PGPC_PULL_HI          14
`define PGPC_PULL_LO          13
`define PGPC_IRQ_MODE_BIT     12
`define PGPC_SUPPLY_BIT       11
`define PGPC_POL_BIT          10
`define PGPC_OD_BIT           9
`define PGPC_ENA_BIT          7
`define PGPC_FN_HI            3
`define PGPC_FN_LO            0

// ****************************************
// reset values and masks
// ****************************************
`define PGPC_CTRL_RESET       16'ha400
`define PGPC_CTRL_WMASK       16'hfe8f

`endif

// ==== rtl/pgpc_out_mux.sv ====
/*
 * output function selector for one pin.
 * assumes all source signals are synchronous to the clock.
 */
module pgpc_out_mux (
    input  wire logic [3:0]  i_fn,
    input  wire logic        i_data,
    input  wire logic        i_osc32k,
    input  wire logic        i_on_state,
    input  wire logic        i_sleep_state,
    input  wire logic        i_pwr_change,
    input  wire logic [1:0]  i_vs_done,
    input  wire logic [1:0]  i_ext_en,
    input  wire logic        i_system_supply_good,
    input  wire logic        i_converter_power_good,
    input  wire logic        i_clk2m,
    input  wire logic        i_aux_rst,
    output logic             o_level
);
    always_comb begin
        case (pgpc_pkg::pgpc_out_fn_t'(i_fn))
            pgpc_pkg::PGPC_OFN_DATA:    o_level = i_data;
            pgpc_pkg::PGPC_OFN_OSC32K:  o_level = i_osc32k;
            pgpc_pkg::PGPC_OFN_ON:      o_level = i_on_state;
            pgpc_pkg::PGPC_OFN_SLEEP:   o_level = i_sleep_state;
            pgpc_pkg::PGPC_OFN_PSCHG:   o_level = i_pwr_change;
            pgpc_pkg::PGPC_OFN_VSDONE1: o_level = i_vs_done[0];
            pgpc_pkg::PGPC_OFN_VSDONE2: o_level = i_vs_done[1];
            pgpc_pkg::PGPC_OFN_EXTEN1:  o_level = i_ext_en[0];
            pgpc_pkg::PGPC_OFN_EXTEN2:  o_level = i_ext_en[1];
            pgpc_pkg::PGPC_OFN_SYSGOOD: o_level = i_system_supply_good;
            pgpc_pkg::PGPC_OFN_PWRGOOD: o_level = i_converter_power_good;
            pgpc_pkg::PGPC_OFN_CLK2M:   o_level = i_clk2m;
            pgpc_pkg::PGPC_OFN_AUXRST:  o_level = i_aux_rst;
            // reserved codes 5..7 hold the pin at its inactive level
            default:                    o_level = 1'b0;
        endcase
    end
endmodule : pgpc_out_mux

// ==== rtl/pgpc_pin_config.sv ====
/*
 * two-pin configuration block: control registers, pad controls,
 * input function decode, output function select and pin interrupts.
 * assumes a one-cycle register port and pins synchronous to i_core_clk.
 */
// The strobed register port was decided locally.
// Contract
// - enable 0 tristates pin; direction 1 input, 0 output, resets input
// - pull field 00 none, 01 down, 10 up, 11 reserved, resets down
// - edge mode 0: one edge, rising if polarity 1, falling otherwise
// - edge mode 1: interrupt on both edges whatever the polarity
// - polarity 0 inverted active low, 1 active high, resets to 1
// - open-drain bit 0 push-pull, 1 open drain, resets push-pull
// - supply bit 0 digital io supply, 1 alternative supply, resets 0
// - input codes 0..4: gpio long/short, on-off, sleep-wake, sleep-wake long
// - input codes 5..9: sleep, power-on, watchdog reset, scale select 1,2
// - input codes 10..15: hw enables, hw controls, hw controls long debounce
// - output codes 0..4: data, 32k clock, on, sleep, state change; 5..7 reserved
// - output codes 8..15: scale done, ext enables, goods, 2MHz, aux reset
// - two identical pin registers at consecutive addresses
module pgpc_pin_config (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    output logic             o_irq,
    input  wire logic [1:0]  i_pin,
    output logic      [1:0]  o_pin,
    output logic      [1:0]  o_pin_oe,
    output logic      [1:0]  o_pull_up_en,
    output logic      [1:0]  o_pull_down_en,
    output logic      [1:0]  o_supply_alt_sel,
    input  wire logic        i_osc32k,
    input  wire logic        i_on_state,
    input  wire logic        i_sleep_state,
    input  wire logic        i_pwr_change,
    input  wire logic [1:0]  i_vs_done,
    input  wire logic [1:0]  i_ext_en,
    input  wire logic        i_system_supply_good,
    input  wire logic        i_converter_power_good,
    input  wire logic        i_clk2m,
    input  wire logic        i_aux_rst,
    output logic             o_gpio_in_long,
    output logic             o_gpio_in,
    output logic             o_on_off_req,
    output logic             o_sleep_wake_req,
    output logic             o_sleep_wake_req_long,
    output logic             o_sleep_req,
    output logic             o_power_on_req,
    output logic             o_watchdog_rst,
    output logic             o_voltage_scale_sel_one,
    output logic             o_voltage_scale_sel_two,
    output logic      [1:0]  o_hw_enable,
    output logic      [1:0]  o_hw_control,
    output logic      [1:0]  o_hw_control_long
);

    `include "pgpc_map.svh"

    // ****************************************
    // control registers
    // ****************************************
    logic [15:0] ctrl_q [2];
    logic [1:0]  data_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_en_q;
    logic [1:0]  irq_evt;
    logic [15:0] rdata_q;
    logic        wr_a;
    logic        wr_b;

    assign wr_a = i_wr && (i_addr == `PGPC_PIN_A_CTRL_OFS);
    assign wr_b = i_wr && (i_addr == `PGPC_PIN_B_CTRL_OFS);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ctrl_q[0] <= `PGPC_CTRL_RESET;
        end else if (wr_a) begin
            ctrl_q[0] <= i_wdata & `PGPC_CTRL_WMASK;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ctrl_q[1] <= `PGPC_CTRL_RESET;
        end else if (wr_b) begin
            ctrl_q[1] <= i_wdata & `PGPC_CTRL_WMASK;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            data_q <= 2'h0;
        end else if (i_wr && (i_addr == `PGPC_PIN_DATA_OFS)) begin
            data_q <= i_wdata[1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_en_q <= 2'h0;
        end else if (i_wr && (i_addr == `PGPC_IRQ_EN_OFS)) begin
            irq_en_q <= i_wdata[1:0];
        end
    end

    // a new edge wins over a clear in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_stat_q <= 2'h0;
        end else if (i_wr && (i_addr == `PGPC_IRQ_CLR_OFS)) begin
            irq_stat_q <= (irq_stat_q & ~i_wdata[1:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |((irq_stat_q | irq_evt) & irq_en_q);
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_q <= 16'h0000;
        end else if (!i_rd) begin
            rdata_q <= 16'h0000;
        end else if (i_addr == `PGPC_PIN_A_CTRL_OFS) begin
            rdata_q <= ctrl_q[0];
        end else if (i_addr == `PGPC_PIN_B_CTRL_OFS) begin
            rdata_q <= ctrl_q[1];
        end else if (i_addr == `PGPC_IRQ_STAT_OFS) begin
            rdata_q <= {14'h0000, irq_stat_q};
        end else if (i_addr == `PGPC_IRQ_EN_OFS) begin
            rdata_q <= {14'h0000, irq_en_q};
        end else if (i_addr == `PGPC_PIN_DATA_OFS) begin
            rdata_q <= {12'h000, i_pin, data_q};
        end else begin
            // clear register and unmapped addresses read zero
            rdata_q <= 16'h0000;
        end
    end

    assign o_rdata = rdata_q;

    // ****************************************
    // per-pin pad control and interrupts
    // ****************************************
    logic [1:0]  mux_level;
    logic [3:0]  in_fn [2];
    pgpc_pkg::pgpc_state_t pin_state [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic ena;
            logic is_in;
            logic pol;
            logic od;
            logic drive;
            pgpc_pkg::pgpc_pull_t pull;

            assign ena   = ctrl_q[g][`PGPC_ENA_BIT];
            assign is_in = ctrl_q[g][`PGPC_DIR_BIT];
            assign pol   = ctrl_q[g][`PGPC_POL_BIT];
            assign od    = ctrl_q[g][`PGPC_OD_BIT];
            assign pull  = pgpc_pkg::pgpc_pull_t'(ctrl_q[g][`PGPC_PULL_HI:`PGPC_PULL_LO]);
            assign in_fn[g] = ctrl_q[g][`PGPC_FN_HI:`PGPC_FN_LO];

            always_comb begin
                if (!ena) begin
                    pin_state[g] = pgpc_pkg::PGPC_ST_OFF;
                end else if (is_in) begin
                    pin_state[g] = pgpc_pkg::PGPC_ST_IN;
                end else begin
                    pin_state[g] = pgpc_pkg::PGPC_ST_OUT;
                end
            end

            pgpc_out_mux u_mux (
                .i_fn                   (in_fn[g]),
                .i_data                 (data_q[g]),
                .i_osc32k               (i_osc32k),
                .i_on_state             (i_on_state),
                .i_sleep_state          (i_sleep_state),
                .i_pwr_change           (i_pwr_change),
                .i_vs_done              (i_vs_done),
                .i_ext_en               (i_ext_en),
                .i_system_supply_good   (i_system_supply_good),
                .i_converter_power_good (i_converter_power_good),
                .i_clk2m                (i_clk2m),
                .i_aux_rst              (i_aux_rst),
                .o_level                (mux_level[g])
            );

            assign drive = pol ? mux_level[g] : ~mux_level[g];

            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    o_pin[g]    <= 1'b0;
                    o_pin_oe[g] <= 1'b0;
                end else if (pin_state[g] != pgpc_pkg::PGPC_ST_OUT) begin
                    o_pin[g]    <= 1'b0;
                    o_pin_oe[g] <= 1'b0;
                end else if (od) begin
                    o_pin[g]    <= 1'b0;
                    o_pin_oe[g] <= ~drive;
                end else begin
                    o_pin[g]    <= drive;
                    o_pin_oe[g] <= 1'b1;
                end
            end

            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    o_pull_up_en[g]     <= 1'b0;
                    o_pull_down_en[g]   <= 1'b0;
                    o_supply_alt_sel[g] <= 1'b0;
                end else begin
                    o_pull_up_en[g]     <= (pull == pgpc_pkg::PGPC_PULL_UP);
                    o_pull_down_en[g]   <= (pull == pgpc_pkg::PGPC_PULL_DOWN);
                    o_supply_alt_sel[g] <= ctrl_q[g][`PGPC_SUPPLY_BIT];
                end
            end

            pgpc_edge_detect u_edge (
                .i_core_clk   (i_core_clk),
                .i_rst_n      (i_rst_n),
                .i_level      (i_pin[g]),
                .i_polarity   (pol),
                .i_both_edges (ctrl_q[g][`PGPC_IRQ_MODE_BIT]),
                .i_arm        (pin_state[g] == pgpc_pkg::PGPC_ST_IN),
                .o_event      (irq_evt[g])
            );
        end
    endgenerate

    // ****************************************
    // input function decode
    // ****************************************
    // pin a has priority when both pins pick the same function
    logic [15:0] fn_hit;
    logic [15:0] fn_lvl;

    always_comb begin
        fn_hit = 16'h0000;
        fn_lvl = 16'h0000;
        for (int p = 1; p >= 0; p--) begin
            if (pin_state[p] == pgpc_pkg::PGPC_ST_IN) begin
                fn_hit[in_fn[p]] = 1'b1;
                // active level follows polarity
                fn_lvl[in_fn[p]] = ctrl_q[p][`PGPC_POL_BIT] ? i_pin[p] : ~i_pin[p];
            end
        end
    end

    // debounce lives outside; these are qualified levels only
    // codes 0..15
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_gpio_in_long          <= 1'b0;
            o_gpio_in               <= 1'b0;
            o_on_off_req            <= 1'b0;
            o_sleep_wake_req        <= 1'b0;
            o_sleep_wake_req_long   <= 1'b0;
            o_sleep_req             <= 1'b0;
            o_power_on_req          <= 1'b0;
            o_watchdog_rst          <= 1'b0;
            o_voltage_scale_sel_one <= 1'b0;
            o_voltage_scale_sel_two <= 1'b0;
            o_hw_enable             <= 2'h0;
            o_hw_control            <= 2'h0;
            o_hw_control_long       <= 2'h0;
        end else begin
            o_gpio_in_long          <= fn_hit[0] & fn_lvl[0];
            o_gpio_in               <= fn_hit[1] & fn_lvl[1];
            o_on_off_req            <= fn_hit[2] & fn_lvl[2];
            o_sleep_wake_req        <= fn_hit[3] & fn_lvl[3];
            o_sleep_wake_req_long   <= fn_hit[4] & fn_lvl[4];
            o_sleep_req             <= fn_hit[5] & fn_lvl[5];
            o_power_on_req          <= fn_hit[6] & fn_lvl[6];
            o_watchdog_rst          <= fn_hit[7] & fn_lvl[7];
            o_voltage_scale_sel_one <= fn_hit[8] & fn_lvl[8];
            o_voltage_scale_sel_two <= fn_hit[9] & fn_lvl[9];
            o_hw_enable             <= fn_hit[11:10] & fn_lvl[11:10];
            o_hw_control            <= fn_hit[13:12] & fn_lvl[13:12];
            o_hw_control_long       <= fn_hit[15:14] & fn_lvl[15:14];
        end
    end

endmodule : pgpc_pin_config

// ==== rtl/pgpc_pkg.sv ====
/*
 * types shared by the pin-control block.
 * assumes nothing beyond the map header.
 */
package pgpc_pkg;

    typedef enum logic [1:0] {
        PGPC_PULL_NONE = 2'h0,
        PGPC_PULL_DOWN = 2'h1,
        PGPC_PULL_UP   = 2'h2,
        PGPC_PULL_RSVD = 2'h3
    } pgpc_pull_t;

    typedef enum logic [3:0] {
        PGPC_OFN_DATA     = 4'h0,
        PGPC_OFN_OSC32K   = 4'h1,
        PGPC_OFN_ON       = 4'h2,
        PGPC_OFN_SLEEP    = 4'h3,
        PGPC_OFN_PSCHG    = 4'h4,
        PGPC_OFN_VSDONE1  = 4'h8,
        PGPC_OFN_VSDONE2  = 4'h9,
        PGPC_OFN_EXTEN1   = 4'ha,
        PGPC_OFN_EXTEN2   = 4'hb,
        PGPC_OFN_SYSGOOD  = 4'hc,
        PGPC_OFN_PWRGOOD  = 4'hd,
        PGPC_OFN_CLK2M    = 4'he,
        PGPC_OFN_AUXRST   = 4'hf
    } pgpc_out_fn_t;

    typedef enum logic [2:0] {
        PGPC_ST_OFF = 3'b001,
        PGPC_ST_IN  = 3'b010,
        PGPC_ST_OUT = 3'b100
    } pgpc_state_t;

endpackage : pgpc_pkg

// ==== sim/pgpc_pin_config_properties.sv ====
/* port checker for the pin-control block, with a shadow of the written registers.
   assumes the bus never waits and the irq enable resets to zero. */
`include "pgpc_map.svh"
module pgpc_pin_config_chk (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        o_irq,
    input wire logic [1:0]  i_pin,
    input wire logic [1:0]  o_pin,
    input wire logic [1:0]  o_pin_oe,
    input wire logic [1:0]  o_pull_up_en,
    input wire logic [1:0]  o_pull_down_en,
    input wire logic [1:0]  o_supply_alt_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ctl_q [2];
    logic [15:0] sel_v;
    logic [1:0]  ien_q;
    logic        up_q;
    logic [1:0]  off_v, in_v, od_v, pu_v, pd_v, alt_v;
    // ****************************************
    // register shadow
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        up_q <= i_rst_n;
        if (!i_rst_n) begin
            ctl_q[0] <= `PGPC_CTRL_RESET;
            ctl_q[1] <= `PGPC_CTRL_RESET;
            ien_q    <= 2'h0;
        end else if (i_wr) begin
            if (i_addr == `PGPC_PIN_A_CTRL_OFS) ctl_q[0] <= i_wdata & `PGPC_CTRL_WMASK;
            if (i_addr == `PGPC_PIN_B_CTRL_OFS) ctl_q[1] <= i_wdata & `PGPC_CTRL_WMASK;
            if (i_addr == `PGPC_IRQ_EN_OFS) ien_q <= i_wdata[1:0];
        end
    end
    always_comb begin
        sel_v = (i_addr == `PGPC_PIN_A_CTRL_OFS) ? ctl_q[0] : ctl_q[1];
        for (int i = 0; i < 2; i++) begin
            off_v[i] = !ctl_q[i][7] || ctl_q[i][15];
            in_v[i]  = ctl_q[i][7] && ctl_q[i][15];
            od_v[i]  = ctl_q[i][9];
            pu_v[i]  = ctl_q[i][14:13] == 2'h2;
            pd_v[i]  = ctl_q[i][14:13] == 2'h1;
            alt_v[i] = ctl_q[i][11];
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    // stability guards accept either output register timing
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_oe_tristate: assert property (
        ((off_v & $past(off_v)) & o_pin_oe) == 2'h0)
        else $error("pin driven while disabled or input");
    chk_pull_select: assert property (
        up_q && $stable(pu_v) && $stable(pd_v) |->
        o_pull_up_en == pu_v && o_pull_down_en == pd_v)
        else $error("pull controls differ from pull field");
    chk_supply_sel: assert property (
        up_q && $stable(alt_v) |-> o_supply_alt_sel == alt_v)
        else $error("supply select differs from control bit");
    chk_od_low_only: assert property (
        (o_pin_oe & o_pin & od_v & $past(od_v)) == 2'h0)
        else $error("open drain pin driven high");
    chk_edge_single: assert property (
        up_q && in_v[0] && !ctl_q[0][12] && ien_q[0] &&
        (ctl_q[0][10] ? $rose(i_pin[0]) : $fell(i_pin[0])) |=> o_irq)
        else $error("single edge gave no interrupt");
    chk_edge_both: assert property (
        up_q && in_v[1] && ctl_q[1][12] && ien_q[1] && $changed(i_pin[1]) |=> o_irq)
        else $error("either edge gave no interrupt");
    chk_irq_masked: assert property (
        ien_q == 2'h0 && $past(ien_q) == 2'h0 |-> !o_irq)
        else $error("interrupt raised while masked");
    chk_read_ctrl: assert property (
        i_rd && (i_addr == `PGPC_PIN_A_CTRL_OFS || i_addr == `PGPC_PIN_B_CTRL_OFS)
        |=> o_rdata == $past(sel_v))
        else $error("control readback differs");
    chk_read_idle: assert property (
        !$past(i_rd) |-> o_rdata == 16'h0)
        else $error("read data outside read cycle");
endmodule : pgpc_pin_config_chk
bind pgpc_pin_config pgpc_pin_config_chk chk_u (.i_core_clk, .i_rst_n, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_irq, .i_pin, .o_pin, .o_pin_oe, .o_pull_up_en,
    .o_pull_down_en, .o_supply_alt_sel);

// ==== sim/pgpc_pin_config_tb.sv ====
/* self-checking bench: bus tasks, pin world, function tables per pin.
   assumes the port checker is bound in by its own file. */
`include "pgpc_map.svh"
module pgpc_pin_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PA = `PGPC_PIN_A_CTRL_OFS;
    logic        i_core_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [15:0] i_addr = 16'h0, i_wdata = 16'h0, o_rdata, fv;
    logic [11:0] src = 12'h0;
    logic [1:0]  ext_val = 2'h0, ext_en = 2'h0, i_pin, o_pin, o_pin_oe, o_supply_alt_sel;
    logic [1:0]  o_pull_up_en, o_pull_down_en, i_vs_done, i_ext_en, o_hw_enable;
    logic [1:0]  o_hw_control, o_hw_control_long;
    logic        o_irq, i_osc32k, i_on_state, i_sleep_state, i_pwr_change, i_clk2m;
    logic        i_system_supply_good, i_converter_power_good, i_aux_rst, o_gpio_in;
    logic        o_gpio_in_long, o_on_off_req, o_sleep_wake_req, o_sleep_wake_req_long;
    logic        o_sleep_req, o_power_on_req, o_watchdog_rst;
    logic        o_voltage_scale_sel_one, o_voltage_scale_sel_two;
    int          n_mismatch = 0, total_checks = 0, cyc_n = 0, en_m = 0;
    int          ctl_m [2] = '{`PGPC_CTRL_RESET, `PGPC_CTRL_RESET};
    assign {i_aux_rst, i_clk2m, i_converter_power_good, i_system_supply_good, i_ext_en,
            i_vs_done, i_pwr_change, i_sleep_state, i_on_state, i_osc32k} = src;
    // one bit per input function code, code 0 at bit 0
    assign fv = {o_hw_control_long, o_hw_control, o_hw_enable, o_voltage_scale_sel_two,
                 o_voltage_scale_sel_one, o_watchdog_rst, o_power_on_req, o_sleep_req,
                 o_sleep_wake_req_long, o_sleep_wake_req, o_on_off_req, o_gpio_in,
                 o_gpio_in_long};
    pgpc_pin_world world_u (.i_core_clk, .i_drv(o_pin), .i_drv_oe(o_pin_oe),
        .i_pull_up(o_pull_up_en), .i_pull_down(o_pull_down_en), .i_ext_val(ext_val),
        .i_ext_en(ext_en), .o_level(i_pin));
    pgpc_pin_config dut_u (.i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_irq, .i_pin, .o_pin, .o_pin_oe, .o_pull_up_en, .o_pull_down_en,
        .o_supply_alt_sel, .i_osc32k, .i_on_state, .i_sleep_state, .i_pwr_change,
        .i_vs_done, .i_ext_en, .i_system_supply_good, .i_converter_power_good, .i_clk2m,
        .i_aux_rst, .o_gpio_in_long, .o_gpio_in, .o_on_off_req, .o_sleep_wake_req,
        .o_sleep_wake_req_long, .o_sleep_req, .o_power_on_req, .o_watchdog_rst,
        .o_voltage_scale_sel_one, .o_voltage_scale_sel_two, .o_hw_enable, .o_hw_control,
        .o_hw_control_long);
    // ****************************************
    // clock, timeout and tasks
    // ****************************************
    always #4 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] seen, input int exp);
        total_checks++;
        if (seen !== 16'(exp)) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, 16'(exp));
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        if (a == PA || a == PA + 16'h1) ctl_m[a - PA] = d & `PGPC_CTRL_WMASK;
        if (a == `PGPC_IRQ_EN_OFS) en_m = d[1:0];
    endtask : wr
    task automatic rd(input logic [15:0] a, input int e);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask : rd
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        int p, lv, od, pol, c, m, r, e;
        void'($urandom(10604));
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        cyc(2);
        chk(o_pull_down_en, 3);
        chk(o_pin_oe, 0);
        chk(o_supply_alt_sel, 0);
        rd(PA, `PGPC_CTRL_RESET);
        rd(PA + 16'h1, `PGPC_CTRL_RESET);
        rd(16'h4000, 0);
        wr(`PGPC_IRQ_EN_OFS, 16'h0);
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            wr(PA + 16'(k % 2), r[15:0]);
            rd(PA + 16'(k % 2), ctl_m[k % 2]);
        end
        wr(16'h4039, 16'hffff);
        rd(PA, ctl_m[0]);
        for (c = 0; c < 4; c++) begin
            wr(PA, 16'(c << 13) | 16'h0800);
            cyc(2);
            chk(o_pull_up_en[0], c == 2);
            chk(o_pull_down_en[0], c == 1);
            chk(o_supply_alt_sel, 2 * ctl_m[1][11] + 1);
        end
        $display("test registers done");
        for (p = 0; p < 2; p++) begin
            // park the other pin as an output so it feeds no input function
            wr(PA + 16'(1 - p), 16'h0480);
            ext_en <= 2'(1 << p);
            for (int fn = 0; fn < 16; fn++) begin
                pol = $urandom % 2;
                od = $urandom % 2;
                r = $urandom;
                wr(PA + 16'(p), 16'h0080 | 16'(pol << 10) | 16'(od << 9) | 16'(fn));
                wr(`PGPC_PIN_DATA_OFS, 16'(r[13:12]));
                src <= r[11:0];
                e = fn == 0 ? r[12 + p] : (fn > 4 && fn < 8) ? 0 : r[fn < 8 ? fn - 1 : fn - 4];
                e = e ^ (pol == 0);
                cyc(3);
                chk(o_pin_oe[p], od ? !e : 1);
                if (od == 0) chk(o_pin[p], e);
            end
            wr(PA + 16'(p), 16'h0400);
            cyc(2);
            chk(o_pin_oe[p], 0);
            for (int fn = 0; fn < 16; fn++) begin
                pol = $urandom % 2;
                lv = $urandom % 2;
                wr(PA + 16'(p), 16'h8080 | 16'(pol << 10) | 16'(fn));
                ext_val[p] <= lv[0];
                cyc(3);
                chk(fv, lv == pol ? 1 << fn : 0);
            end
            for (c = 0; c < 8; c++) begin
                m = c / 4;
                pol = (c / 2) % 2;
                lv = c % 2;
                wr(`PGPC_IRQ_EN_OFS, 16'($urandom % 4));
                wr(PA + 16'(p), 16'h8080 | 16'(m << 12) | 16'(pol << 10));
                ext_val[p] <= (lv == 0);
                cyc(3);
                wr(`PGPC_IRQ_CLR_OFS, 16'h3);
                ext_val[p] <= lv[0];
                cyc(3);
                e = m | (lv == pol);
                rd(`PGPC_IRQ_STAT_OFS, e << p);
                chk(o_irq, e & (en_m >> p));
                rd(`PGPC_IRQ_EN_OFS, en_m);
                wr(`PGPC_IRQ_CLR_OFS, 16'h3);
                rd(`PGPC_IRQ_STAT_OFS, 0);
            end
            wr(`PGPC_IRQ_EN_OFS, 16'h0);
            $display("test pin %0d done", p);
        end
        close_out();
    end
endmodule : pgpc_pin_config_tb

// ==== sim/pgpc_pin_world.sv ====
/* the two pin wires as seen by the system logic around the block.
   where the bench drives a pin that the block drives, the block's drive wins. */
module pgpc_pin_world (
    input  wire logic       i_core_clk,
    input  wire logic [1:0] i_drv,
    input  wire logic [1:0] i_drv_oe,
    input  wire logic [1:0] i_pull_up,
    input  wire logic [1:0] i_pull_down,
    input  wire logic [1:0] i_ext_val,
    input  wire logic [1:0] i_ext_en,
    output logic      [1:0] o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last_q = 2'h0;
    always_ff @(posedge i_core_clk) last_q <= o_level;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (i_drv_oe[i]) o_level[i] = i_drv[i];
            else if (i_ext_en[i]) o_level[i] = i_ext_val[i];
            else if (i_pull_up[i]) o_level[i] = 1'b1;
            else if (i_pull_down[i]) o_level[i] = 1'b0;
            // floating wire must not look like a held level
            else o_level[i] = !last_q[i];
        end
    end
endmodule : pgpc_pin_world
